// ---- vsid_pkg.sv ----
// vsid_pkg: register map, field layout, reset values and codes for the slave image decoder
// assumes: 32-bit aligned register words reached over axi4-lite, one clock domain
`default_nettype none
package vsid_pkg;
	// --------------------------------------------------------
	// register offsets (byte addresses)
	// --------------------------------------------------------
	localparam logic [11:0] OFS_CSR      = 12'hf00;
	localparam logic [11:0] OFS_STAT     = 12'hf04;
	localparam logic [11:0] OFS_I5_CTL   = 12'hfa4;
	localparam logic [11:0] OFS_I5_BASE  = 12'hfa8;
	localparam logic [11:0] OFS_I5_BOUND = 12'hfac;
	localparam logic [11:0] OFS_I5_XOFS  = 12'hfb0;
	localparam logic [11:0] OFS_I6_CTL   = 12'hfb8;
	localparam logic [11:0] OFS_I6_BASE  = 12'hfbc;
	localparam logic [11:0] OFS_I6_BOUND = 12'hfc0;
	localparam logic [11:0] OFS_I6_XOFS  = 12'hfc4;
	// --------------------------------------------------------
	// control word field positions
	// --------------------------------------------------------
	localparam int CTL_EN     = 31;
	localparam int CTL_POST   = 30;
	localparam int CTL_PREF   = 29;
	localparam int CTL_CLS_LO = 22;
	localparam int CTL_SUP_LO = 20;
	localparam int CTL_SPC_LO = 16;
	localparam int CTL_WIDE   = 7;
	localparam int CTL_LOCK   = 6;
	localparam int CTL_PSP_LO = 0;
	localparam int CSR_MST    = 2;
	localparam int WIN_LO     = 16;
	// --------------------------------------------------------
	// reset values and writable masks
	// --------------------------------------------------------
	localparam logic [31:0] RST_CTL  = 32'h00f00000;
	localparam logic [31:0] RST_WIN  = 32'h00000000;
	localparam logic [31:0] RST_CSR  = 32'h00000000;
	localparam logic [31:0] MASK_CTL = 32'he0f700c3;
	localparam logic [31:0] MASK_WIN = 32'hffff0000;
	localparam logic [31:0] MASK_CSR = 32'h00000004;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;
	// --------------------------------------------------------
	// codes
	// --------------------------------------------------------
	typedef enum logic [2:0] {VS_A24 = 3'h1, VS_A32 = 3'h2, VS_USER1 = 3'h6, VS_USER2 = 3'h7} vsid_vspace_e;
	typedef enum logic [1:0] {PS_MEM = 2'h0, PS_IO = 2'h1, PS_CFG = 2'h2, PS_RSV = 2'h3} vsid_pspace_e;
	typedef enum logic {LK_IDLE = 1'b0, LK_HELD = 1'b1} vsid_lock_e;
endpackage : vsid_pkg
`default_nettype wire

// ---- vsid_img_if.sv ----
// vsid_img_if: one slave image's settings, from the register file to its decoder
// assumes: the register file drives every field, the decoder only reads them
`default_nettype none
interface vsid_img_if;
	logic        en;
	logic        posted_write_on;
	logic        prefetch_read_on;
	logic [1:0]  program_data_class;
	logic [1:0]  sup;
	logic [2:0]  vme_space_select;
	logic        wide;
	logic        lock;
	logic [1:0]  pci_space_select;
	logic [15:0] base;
	logic [15:0] bound;
	logic [15:0] xofs;
	modport cfg (output en, posted_write_on, prefetch_read_on, program_data_class, sup, vme_space_select, wide,
		lock, pci_space_select, base, bound, xofs);
	modport dec (input en, posted_write_on, prefetch_read_on, program_data_class, sup, vme_space_select, wide,
		lock, pci_space_select, base, bound, xofs);
endinterface : vsid_img_if
`default_nettype wire

// ---- vsid_image_match.sv ----
// vsid_image_match: combinational claim decision and address translation for one image
// assumes: cycle inputs are stable and on the same clock as the register file
`default_nettype none
module vsid_image_match
	import vsid_pkg::*;
(
	vsid_img_if.dec           img,
	input  wire logic         bus_master_on,
	input  wire logic [31:0]  vme_addr,
	input  wire logic [2:0]   vme_space,
	input  wire logic         vme_program,
	input  wire logic         vme_super,
	output logic              hit,
	output logic [31:0]       dest_addr
);
	// --------------------------------------------------------
	// class, space and window checks
	// --------------------------------------------------------
	logic class_ok, priv_ok, space_ok, above_base, below_bound;
	assign class_ok    = vme_program ? img.program_data_class[1] : img.program_data_class[0];
	assign priv_ok     = vme_super ? img.sup[1] : img.sup[0];
	// reserved space codes never equal a valid one, so they never decode
	assign space_ok    = (img.vme_space_select == vme_space)
		&& (img.vme_space_select inside {VS_A24, VS_A32, VS_USER1, VS_USER2});
	assign above_base  = vme_addr[31:WIN_LO] >= img.base;
	assign below_bound = (img.bound == 16'h0000) || (vme_addr[31:WIN_LO] < img.bound);
	// reserved pci space is never forwarded
	assign hit = img.en && bus_master_on && class_ok && priv_ok && space_ok && above_base && below_bound
		&& (img.pci_space_select != PS_RSV);
	// modular add: a two's complement offset subtracts
	assign dest_addr = {vme_addr[31:WIN_LO] + img.xofs, vme_addr[WIN_LO-1:0]};
endmodule : vsid_image_match
`default_nettype wire

// ---- vsid_fwd_reg.sv ----
// vsid_fwd_reg: output register stage for the forwarded pci request
// assumes: load is a one-cycle pulse on the same clock
`default_nettype none
module vsid_fwd_reg
	import vsid_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic        load,
	input  wire logic [31:0] in_addr,
	input  wire logic [1:0]  in_space,
	input  wire logic [3:0]  in_flags,
	input  wire logic [1:0]  in_image,
	output logic             fwd_valid,
	output logic [31:0]      fwd_addr,
	output logic [1:0]       fwd_space,
	output logic [3:0]       fwd_flags,
	output logic [1:0]       fwd_image
);
	// valid pulses one cycle, payload holds until the next claim
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fwd_valid <= 1'b0;
			fwd_addr  <= 32'h00000000;
			fwd_space <= 2'h0;
			fwd_flags <= 4'h0;
			fwd_image <= 2'h0;
		end else if (ce) begin
			fwd_valid <= load;
			if (load) begin
				fwd_addr  <= in_addr;
				fwd_space <= in_space;
				fwd_flags <= in_flags;
				fwd_image <= in_image;
			end
		end
	end
endmodule : vsid_fwd_reg
`default_nettype wire

// ---- vsid_slave_decode.sv ----
// vsid_slave_decode: two backplane slave images forwarding cycles to the local pci side
// assumes: an axi4-lite master on aclk, and cycle requests from logic on the same clock
//
// Chosen here: the AXI4-Lite interface to the registers.
`default_nettype none
// What this block does
// - program/data class must match image field
// - privilege class must match image field
// - three-bit space field picks decoded space
// - two-bit field picks forwarded pci space
// - wide pci only when its bit set
// - lock pci during rmw when enabled
// - only memory-space writes are posted
// - post/prefetch ignored outside memory space
// - no response without bus-master enable
// - claim base up to below bound
// - zero bound means no upper limit
// - destination is source plus offset
// - windows use bits 31:16, 64k granularity
// - control fields in bits 31-16, 07-00
// - image control words at fixed offsets
module vsid_slave_decode
	import vsid_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        vme_valid,
	input  wire logic [31:0] vme_addr,
	input  wire logic [2:0]  vme_space,
	input  wire logic        vme_program,
	input  wire logic        vme_super,
	input  wire logic        vme_write,
	input  wire logic        vme_rmw,
	input  wire logic        vme_rmw_end,
	output logic             fwd_valid,
	output logic [31:0]      fwd_addr,
	output logic [1:0]       fwd_space,
	output logic             fwd_write,
	output logic             fwd_posted,
	output logic             fwd_prefetch,
	output logic             fwd_wide,
	output logic [1:0]       fwd_image,
	output logic             vme_ignored,
	output logic             pci_lock
);
	// --------------------------------------------------------
	// register index decode
	// --------------------------------------------------------
	// index 0 is unmapped; 3+4*i+k is image i, word k (ctl, base, bound, offset)
	function automatic logic [3:0] reg_idx(input logic [11:0] a);
		case (a)
			OFS_CSR:      reg_idx = 4'h1;
			OFS_STAT:     reg_idx = 4'h2;
			OFS_I5_CTL:   reg_idx = 4'h3;
			OFS_I5_BASE:  reg_idx = 4'h4;
			OFS_I5_BOUND: reg_idx = 4'h5;
			OFS_I5_XOFS:  reg_idx = 4'h6;
			OFS_I6_CTL:   reg_idx = 4'h7;
			OFS_I6_BASE:  reg_idx = 4'h8;
			OFS_I6_BOUND: reg_idx = 4'h9;
			OFS_I6_XOFS:  reg_idx = 4'ha;
			default:      reg_idx = 4'h0;
		endcase
	endfunction : reg_idx

	// byte-lane merge, reserved bits forced to zero
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = ((old & ~m) | (d & m)) & mask;
	endfunction : merge

	// --------------------------------------------------------
	// axi4-lite write channel
	// --------------------------------------------------------
	logic        aw_held, w_held;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        do_write, next_aw_held, next_w_held, next_bvalid;
	logic [3:0]  widx;

	// address and data are taken in either order; the write happens once both are held
	assign do_write     = aw_held && w_held && !s_axi_bvalid;
	assign next_aw_held = do_write ? 1'b0 : (aw_held || (s_axi_awvalid && s_axi_awready));
	assign next_w_held  = do_write ? 1'b0 : (w_held || (s_axi_wvalid && s_axi_wready));
	assign next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
	assign widx         = reg_idx(aw_addr_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OK;
		end else if (ce) begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			if (s_axi_awvalid && s_axi_awready) aw_addr_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready  <= !next_w_held && !next_bvalid;
			s_axi_bvalid  <= next_bvalid;
			if (do_write) s_axi_bresp <= (widx == 4'h0) ? RESP_ERR : RESP_OK;
		end
	end

	// --------------------------------------------------------
	// register file
	// --------------------------------------------------------
	logic [31:0] csr;
	logic [31:0] ctl [2];
	logic [31:0] base [2];
	logic [31:0] bound [2];
	logic [31:0] xofs [2];
	logic [31:0] rd_bank [11];
	logic        bus_master_on;
	logic [1:0]  hit;
	logic [31:0] dest [2];
	vsid_img_if  img [2] ();

	// pci command bit that gates every image
	always_ff @(posedge aclk) begin
		if (!aresetn) csr <= RST_CSR;
		else if (ce && do_write && widx == 4'h1) csr <= merge(csr, w_data_q, w_strb_q, MASK_CSR);
	end
	// only the bus-master bit stores; the rest of the command word reads zero
	assign bus_master_on = csr[CSR_MST];

	generate
		for (genvar i = 0; i < 2; i++) begin : g_img
			localparam logic [3:0] IX = 4'(3 + 4 * i);
			// reserved bits never store, so they read back as zero
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ctl[i]   <= RST_CTL;
					base[i]  <= RST_WIN;
					bound[i] <= RST_WIN;
					xofs[i]  <= RST_WIN;
				end else if (ce && do_write) begin
					if (widx == IX) ctl[i] <= merge(ctl[i], w_data_q, w_strb_q, MASK_CTL);
					if (widx == IX + 4'h1) base[i] <= merge(base[i], w_data_q, w_strb_q, MASK_WIN);
					if (widx == IX + 4'h2) bound[i] <= merge(bound[i], w_data_q, w_strb_q, MASK_WIN);
					if (widx == IX + 4'h3) xofs[i] <= merge(xofs[i], w_data_q, w_strb_q, MASK_WIN);
				end
			end
			// field unpacking into the image carrier
			assign img[i].en    = ctl[i][CTL_EN];
			assign img[i].posted_write_on    = ctl[i][CTL_POST];
			assign img[i].prefetch_read_on   = ctl[i][CTL_PREF];
			assign img[i].program_data_class = ctl[i][CTL_CLS_LO +: 2];
			assign img[i].sup                = ctl[i][CTL_SUP_LO +: 2];
			assign img[i].vme_space_select   = ctl[i][CTL_SPC_LO +: 3];
			assign img[i].wide               = ctl[i][CTL_WIDE];
			assign img[i].lock               = ctl[i][CTL_LOCK];
			assign img[i].pci_space_select   = ctl[i][CTL_PSP_LO +: 2];
			assign img[i].base  = base[i][31:WIN_LO];
			assign img[i].bound = bound[i][31:WIN_LO];
			assign img[i].xofs  = xofs[i][31:WIN_LO];
			assign rd_bank[IX]        = ctl[i];
			assign rd_bank[IX + 4'h1] = base[i];
			assign rd_bank[IX + 4'h2] = bound[i];
			assign rd_bank[IX + 4'h3] = xofs[i];
			vsid_image_match u_match (
				.img         (img[i]),
				.bus_master_on (bus_master_on),
				.vme_addr    (vme_addr),
				.vme_space   (vme_space),
				.vme_program (vme_program),
				.vme_super   (vme_super),
				.hit         (hit[i]),
				.dest_addr   (dest[i])
			);
		end
	endgenerate

	// --------------------------------------------------------
	// cycle claim and forwarding
	// --------------------------------------------------------
	logic        claim, sel, sel_mem, sel_wide, sel_lock, sel_post, sel_pref;
	logic [1:0]  sel_pspace;
	logic [3:0]  sel_flags;
	logic [15:0] claim_cnt;
	vsid_lock_e  lock_st, next_lock_st;

	// image 5 wins when both windows overlap
	assign claim     = vme_valid && (hit != 2'b00);
	assign sel       = !hit[0];
	assign sel_pspace = ctl[sel][CTL_PSP_LO +: 2];
	assign sel_mem    = sel_pspace == PS_MEM;
	assign sel_wide   = ctl[sel][CTL_WIDE];
	assign sel_lock   = ctl[sel][CTL_LOCK];
	assign sel_post   = ctl[sel][CTL_POST] && sel_mem;
	assign sel_pref   = ctl[sel][CTL_PREF] && sel_mem;
	// flags: write, posted, prefetch, wide
	assign sel_flags  = {vme_write, vme_write && sel_post, !vme_write && sel_pref, sel_wide};

	vsid_fwd_reg u_fwd (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.load      (claim),
		.in_addr   (dest[sel]),
		.in_space  (sel_pspace),
		.in_flags  (sel_flags),
		.in_image  (sel ? 2'b10 : 2'b01),
		.fwd_valid (fwd_valid),
		.fwd_addr  (fwd_addr),
		.fwd_space (fwd_space),
		.fwd_flags ({fwd_write, fwd_posted, fwd_prefetch, fwd_wide}),
		.fwd_image (fwd_image)
	);

	// lock is held from the claimed rmw until its end pulse
	always_comb begin
		case (lock_st)
			LK_IDLE: next_lock_st = (claim && vme_rmw && sel_lock) ? LK_HELD : LK_IDLE;
			LK_HELD: next_lock_st = vme_rmw_end ? LK_IDLE : LK_HELD;
			default: next_lock_st = LK_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_st     <= LK_IDLE;
			pci_lock    <= 1'b0;
			vme_ignored <= 1'b0;
			claim_cnt   <= 16'h0000;
		end else if (ce) begin
			lock_st     <= next_lock_st;
			pci_lock    <= next_lock_st == LK_HELD;
			vme_ignored <= vme_valid && !claim;
			if (claim) claim_cnt <= claim_cnt + 16'h0001;
		end
	end

	// --------------------------------------------------------
	// axi4-lite read channel
	// --------------------------------------------------------
	logic       next_rvalid;
	logic [3:0] ridx;
	assign rd_bank[0]  = 32'h00000000;
	assign rd_bank[1]  = csr;
	assign rd_bank[2]  = {claim_cnt, 13'h0000, pci_lock, fwd_image};
	assign ridx        = reg_idx(s_axi_araddr);
	assign next_rvalid = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OK;
		end else if (ce) begin
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rdata <= rd_bank[ridx];
				s_axi_rresp <= (ridx == 4'h0) ? RESP_ERR : RESP_OK;
			end
		end
	end

	// --------------------------------------------------------
	// assertions
	// --------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// registered outputs are checked one edge after the cycle that loads them
	dis_no_claim_a: assert property (ce && vme_valid && !ctl[0][CTL_EN] && !ctl[1][CTL_EN] |=> !fwd_valid && vme_ignored)
		else $error("disabled images claimed a cycle");
	pgm_class_a: assert property (ce && claim && !sel && vme_program |-> ctl[0][CTL_CLS_LO + 1])
		else $error("program cycle claimed by data-only image");
	priv_class_a: assert property (ce && claim && !sel && vme_super |-> ctl[0][CTL_SUP_LO + 1])
		else $error("supervisor cycle claimed by user-only image");
	space_match_a: assert property (ce && claim |-> vme_space == ctl[sel][CTL_SPC_LO +: 3])
		else $error("claimed cycle in wrong address space");
	fwd_space_a: assert property (ce && claim |=> fwd_space == $past(sel_pspace) && fwd_space != PS_RSV)
		else $error("forwarded pci space wrong");
	wide_gate_a: assert property (ce && claim && !sel_wide |=> !fwd_wide)
		else $error("wide pci used while disabled");
	lock_rmw_a: assert property (ce && claim && vme_rmw && sel_lock && lock_st == LK_IDLE |=> pci_lock)
		else $error("rmw lock not taken");
	lock_off_a: assert property (ce && lock_st == LK_IDLE && !(claim && vme_rmw && sel_lock) |=> !pci_lock)
		else $error("pci lock without locking rmw");
	post_mem_a: assert property (fwd_posted |-> fwd_write && fwd_space == PS_MEM)
		else $error("posted write outside memory space");
	pref_mem_a: assert property (fwd_prefetch |-> !fwd_write && fwd_space == PS_MEM)
		else $error("prefetch outside memory space");
	bm_gate_a: assert property (ce && !bus_master_on && vme_valid |=> !fwd_valid)
		else $error("cycle claimed without bus-master enable");
	win_low_a: assert property (ce && claim |-> vme_addr[31:WIN_LO] >= base[sel][31:WIN_LO])
		else $error("claimed below base");
	win_high_a: assert property (ce && claim && bound[sel] != 32'h0 |-> vme_addr[31:WIN_LO] < bound[sel][31:WIN_LO])
		else $error("claimed at or above bound");
	open_bound_a: assert property (ce && vme_valid && bus_master_on && hit == 2'b00 && bound[0] == 32'h0
		&& vme_addr[31:WIN_LO] >= base[0][31:WIN_LO] |-> !ctl[0][CTL_EN] || ctl[0][CTL_PSP_LO +: 2] == PS_RSV
		|| ctl[0][CTL_SPC_LO +: 3] != vme_space || !(vme_space inside {VS_A24, VS_A32, VS_USER1, VS_USER2})
		|| !(vme_program ? ctl[0][23] : ctl[0][22])
		|| !(vme_super ? ctl[0][21] : ctl[0][20]))
		else $error("open window refused an address above base");
	xlate_a: assert property (ce && claim |=> fwd_addr == {$past(vme_addr[31:16]) + $past(xofs[sel][31:16]),
		$past(vme_addr[15:0])})
		else $error("translated address wrong");
	rsv_zero_a: assert property (base[0][15:0] == 16'h0 && xofs[1][15:0] == 16'h0 && ctl[0][15:8] == 8'h0)
		else $error("reserved bits stored");
	rd_resp_a: assert property (ce && s_axi_arvalid && s_axi_arready ##1 ce |-> s_axi_rvalid)
		else $error("read answer late");

	claim_c: cover property (ce && claim && hit == 2'b11);
	posted_c: cover property (fwd_valid && fwd_posted);
	lock_c: cover property (pci_lock ##1 !pci_lock);
	wr_c: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OK);
endmodule : vsid_slave_decode
`default_nettype wire

// ---- vsid_vme_master.sv ----
// vsid_vme_master: backplane master model, presents one cycle per request pulse
// assumes: the bench raises go or go_end for one aclk cycle at a time
`default_nettype none
module vsid_vme_master (
	input  wire logic        aclk,
	input  wire logic        go,
	input  wire logic        go_end,
	input  wire logic [31:0] a,
	input  wire logic [6:0]  q,
	output var logic         vme_valid,
	output var logic [31:0]  vme_addr,
	output var logic [2:0]   vme_space,
	output var logic         vme_program,
	output var logic         vme_super,
	output var logic         vme_write,
	output var logic         vme_rmw,
	output var logic         vme_rmw_end
);
	// ----------------------------------------
	// cycle driver
	// ----------------------------------------
	// quiet lines at time zero so the decoder never sees an unknown strobe
	initial begin
		vme_valid = 1'b0;
		vme_rmw_end = 1'b0;
		vme_addr = '0;
		{vme_rmw, vme_write, vme_super, vme_program, vme_space} = '0;
	end
	// between cycles the lines flip, so a stale address never passes for a held one
	always @(posedge aclk) begin
		vme_valid <= go;
		vme_rmw_end <= go_end;
		if (go) begin
			vme_addr <= a;
			{vme_rmw, vme_write, vme_super, vme_program, vme_space} <= q;
		end else begin
			vme_addr <= ~vme_addr;
			{vme_rmw, vme_write, vme_super, vme_program, vme_space} <= ~q;
		end
	end
endmodule : vsid_vme_master
`default_nettype wire

// ---- vsid_slave_decode_tb_top.sv ----
// vsid_slave_decode_tb_top: random images and cycles checked against a reference decoder
// assumes: design files and vsid_vme_master compiled first
`default_nettype none
module vsid_slave_decode_tb_top;
	import vsid_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// signals and reference state
	// ----------------------------------------
	logic        aclk = 0, aresetn = 0, ce = 1, go = 0, go_end = 0, master_on, lk = 0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, vme_addr, fwd_addr, a = '0, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, fwd_space, fwd_image, r;
	logic        vme_valid, vme_program, vme_super, vme_write, vme_rmw, vme_rmw_end;
	logic [2:0]  vme_space;
	logic        fwd_valid, fwd_write, fwd_posted, fwd_prefetch, fwd_wide, vme_ignored, pci_lock;
	logic [6:0]  q = '0;
	logic [31:0] ctl [2], wbase [2], wbound [2], xo [2];
	int          error_cnt = 0, n_checks = 0, seed = 32'h5ed87a92, k;
	always #12.5 aclk = ~aclk;
	vsid_slave_decode dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vme_valid,
		.vme_addr, .vme_space, .vme_program, .vme_super, .vme_write, .vme_rmw, .vme_rmw_end, .fwd_valid,
		.fwd_addr, .fwd_space, .fwd_write, .fwd_posted, .fwd_prefetch, .fwd_wide, .fwd_image, .vme_ignored,
		.pci_lock);
	vsid_vme_master vme (.aclk, .go, .go_end, .a, .q, .vme_valid, .vme_addr, .vme_space, .vme_program,
		.vme_super, .vme_write, .vme_rmw, .vme_rmw_end);
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_sim;
		if (error_cnt == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// address and data offered together, each dropped at its own handshake
	task automatic wr(input logic [11:0] ad, input logic [31:0] wd, output logic [1:0] rs);
		s_axi_awaddr <= ad;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [11:0] ad, output logic [31:0] rdv, output logic [1:0] rs);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rdv = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	// forcing enable and both classes in some rounds keeps the claim rate useful
	task automatic cfg(input int i);
		logic [11:0] o;
		o = i ? OFS_I6_CTL : OFS_I5_CTL;
		ctl[i] = ($random(seed) | (k[2] ? 32'h80f00000 : '0)) & MASK_CTL;
		wbase[i] = $random(seed) & 32'h00f00000;
		wbound[i] = k[0] ? '0 : wbase[i] + 32'h00200000;
		xo[i] = -($random(seed) & 32'h0fff0000);
		wr(o, ctl[i] | 32'h0000ff00, r);
		wr(o + 12'h4, wbase[i] | 32'h0000ffff, r);
		wr(o + 12'h8, wbound[i], r);
		wr(o + 12'hc, xo[i], r);
		rd(o, d, r);
		chk(d, ctl[i]);
		rd(o + 12'h4, d, r);
		chk(d, wbase[i]);
	endtask : cfg
	task automatic cyc;
		int i;
		a = $random(seed) & 32'h00ffffff;
		q = 7'($random(seed));
		if (q[4]) q[2:0] = ctl[q[3]][18:16];
		i = -1;
		for (int j = 1; j >= 0; j--)
			if (master_on && ctl[j][31] && ctl[j][22 + q[3]] && ctl[j][20 + q[4]] && ctl[j][18:16] == q[2:0]
				&& q[2:0] inside {3'h1, 3'h2, 3'h6, 3'h7} && ctl[j][1:0] != 2'h3
				&& a[31:16] >= wbase[j][31:16] && (wbound[j] == 0 || a[31:16] < wbound[j][31:16]))
				i = j;
		if (i >= 0 && q[6] && ctl[i][6]) lk = 1;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		#1;
		chk(fwd_valid, i >= 0);
		chk(vme_ignored, i < 0);
		chk(pci_lock, lk);
		if (i >= 0) begin
			chk(fwd_addr, {a[31:16] + xo[i][31:16], a[15:0]});
			chk(fwd_space, ctl[i][1:0]);
			chk({fwd_image, fwd_write, fwd_wide}, {2'(i + 1), q[5], ctl[i][7]});
			chk({fwd_posted, fwd_prefetch}, {q[5] & ctl[i][30], !q[5] & ctl[i][29]} & {2{ctl[i][1:0] == 0}});
		end
	endtask : cyc
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (k = 0; k < 8; k++) begin
			rd(OFS_I5_CTL + 12'(4 * (k + k / 4)), d, r);
			chk(d, k % 4 ? RST_WIN : RST_CTL);
		end
		rd(12'h004, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'(RESP_ERR));
		wr(12'h008, 32'hffffffff, r);
		chk(r, RESP_ERR);
		for (k = 0; k < 8; k++) begin
			master_on = k[1:0] != 0;
			wr(OFS_CSR, 32'(master_on) << CSR_MST, r);
			cfg(0);
			cfg(1);
			repeat (60) cyc();
			go_end <= 1'b1;
			@(posedge aclk);
			go_end <= 1'b0;
			@(posedge aclk);
			#1;
			lk = 0;
			chk(pci_lock, lk);
			@(posedge aclk);
		end
		// a cycle offered while ce is low must leave no pulse on either answer
		ce <= 1'b0;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		#1;
		chk({fwd_valid, vme_ignored}, 32'h0);
		@(posedge aclk);
		ce <= 1'b1;
		end_sim();
	end
	// the whole run needs under 8000 cycles
	initial begin
		repeat (30000) @(posedge aclk);
		error_cnt++;
		end_sim();
	end
endmodule : vsid_slave_decode_tb_top
`default_nettype wire
